// ===== rtl/cati_top.sv
// Purpose: 16-bit counter array with selectable timebase and one irq
// Assumes: one 100 MHz clock; pins and oscillators are asynchronous
// Notes:   channel mode logic sits outside; it reports events here
// Operation
// [R1] 16-bit count as high and low bytes
// [R2] low read latches high into snapshot
// [R3] reads never disturb counting
// [R4] three-bit selector picks tick source
// [R5] count external input falling edges
// [R6] asynchronous sources synchronised before use
// [R7] wrap from max sets overflow flag
// [R8] overflow irq only when its enable set
// [R9] overflow flag cleared only by software
// [R10] idle ignored when idle-suspend clear
// [R11] intermediate flag from bit 8..11 carry
// [R12] each channel owns an event flag
// [R13] flags set regardless of enables
// [R14] five enabled flags merged into one irq
// [R15] irq needs global and array enable
// [R16] count is shared channel timebase
// [R17] watchdog mode at reset restricts access
// [R18] pwm bits 1:0 choose cycle length
// [R19] one step per tick, reserved none
// [R20] idle-suspend set stops count in idle
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "cati_map.svh"
module cati_top (
    input  wire logic              CLK,      // system clock
    input  wire logic              RST_N,    // async reset, low
    input  wire logic [7:0]        ADDR,     // register address
    input  wire cati_pkg::cati_byte_t WDATA, // write data
    input  wire logic              WR,       // write strobe
    input  wire logic              RD,       // read strobe
    output logic      [7:0]        RDATA,    // read data, cycle after
    input  wire logic              CPU_IDLE, // processor idle level
    input  wire logic              T0_OVF,   // other timer overflow pulse
    input  wire logic              ECI_IN,   // external count pin
    input  wire logic              EXT_OSC,  // external oscillator
    input  wire logic              LF_OSC,   // low-frequency oscillator
    input  wire logic [2:0]        CHAN_EVT, // channel event levels
    output logic      [15:0]       TIMEBASE, // count for channels
    output logic      [2:0]        CHAN_IO_O,  // channel line values
    output logic      [2:0]        CHAN_IO_OE, // channel line enables
    output logic                   WDOG_ON,  // watchdog mode active
    output logic                   IRQ       // combined interrupt
);
    import cati_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [5:0] raw_in;
    logic [5:0] s1_r;
    logic [5:0] s2_r;
    logic [5:0] s3_r;
    assign raw_in = {CHAN_EVT, LF_OSC, EXT_OSC, ECI_IN};

    // two flops per async bit, a third only for edge detection
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    s1_r[gi] <= 1'b0;
                    s2_r[gi] <= 1'b0;
                    s3_r[gi] <= 1'b0;
                end else begin
                    s1_r[gi] <= raw_in[gi]; // see [R6]
                    s2_r[gi] <= s1_r[gi];
                    s3_r[gi] <= s2_r[gi];
                end
            end
        end
    endgenerate

    logic       eci_fall;
    logic       exto_rise;
    logic       lfo_rise;
    logic [2:0] chan_rise;
    assign eci_fall  = s3_r[0] & ~s2_r[0]; // see [R5]
    assign exto_rise = s2_r[1] & ~s3_r[1];
    assign lfo_rise  = s2_r[2] & ~s3_r[2];
    assign chan_rise = s2_r[5:3] & ~s3_r[5:3];

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0]  snap_r, snap_nxt;
    logic [7:0]  mode_r, mode_nxt;
    logic [7:0]  flg_r, flg_nxt;
    logic [7:0]  pwm_r, pwm_nxt;
    logic [7:0]  chan_r, chan_nxt;
    logic [7:0]  ien_r, ien_nxt;
    logic [7:0]  rd_nxt;
    logic [3:0]  p12_r, p12_nxt;
    logic [1:0]  p4_r, p4_nxt;
    logic [2:0]  pe_r, pe_nxt;
    logic [2:0]  pl_r, pl_nxt;
    logic        irq_nxt;

    cati_tb_t sel;
    logic     tick;
    logic     run;
    logic     inc;
    logic     cnt_wr;
    logic     mid_carry;
    logic     wdog;
    logic     ovf_clr;
    assign sel  = cati_tb_t'(mode_r[3:1]);
    assign wdog = mode_r[`CATI_MODE_WDOG];

    // idle only halts the count when suspend is requested
    assign run = ~(mode_r[`CATI_MODE_IDLE] & CPU_IDLE); // see [R10] see [R20]

    // tick source mux, reserved code yields nothing
    always_comb begin
        case (sel)
            CATI_TB_DIV12: tick = (p12_r == `CATI_DIV12_LAST);
            CATI_TB_DIV4:  tick = (p4_r == `CATI_DIV4_LAST);
            CATI_TB_T0OVF: tick = T0_OVF;
            CATI_TB_ECI:   tick = eci_fall;                 // see [R5]
            CATI_TB_SYS:   tick = 1'b1;
            CATI_TB_EXTO:  tick = exto_rise && (pe_r == `CATI_DIV8_LAST);
            CATI_TB_LFO:   tick = lfo_rise && (pl_r == `CATI_DIV8_LAST);
            default:       tick = 1'b0;                     // see [R19]
        endcase
    end // see [R4]

    // a write to a count byte wins over a tick in the same cycle
    assign cnt_wr = WR && !wdog &&
                    (ADDR == `CATI_A_CNT_LO || ADDR == `CATI_A_CNT_HI);
    assign inc    = tick && run && !cnt_wr;

    // carry out of bit 7..10, picked by the cycle length field
    always_comb begin
        case (pwm_r[1:0])
            2'h0:    mid_carry = &cnt_r[7:0];  // see [R18]
            2'h1:    mid_carry = &cnt_r[8:0];
            2'h2:    mid_carry = &cnt_r[9:0];
            default: mid_carry = &cnt_r[10:0];
        endcase
    end

    assign ovf_clr = WR && ADDR == `CATI_A_FLAGS;

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        p12_nxt  = (p12_r == `CATI_DIV12_LAST) ? 4'h0 : p12_r + 4'h1;
        p4_nxt   = p4_r + 2'h1;
        pe_nxt   = exto_rise ? pe_r + 3'h1 : pe_r;
        pl_nxt   = lfo_rise ? pl_r + 3'h1 : pl_r;
        cnt_nxt  = cnt_r;
        snap_nxt = snap_r;
        mode_nxt = mode_r;
        flg_nxt  = flg_r;
        pwm_nxt  = pwm_r;
        chan_nxt = chan_r;
        ien_nxt  = ien_r;
        rd_nxt   = RDATA;
        // software writes; while watchdog is on the count is locked and only its mode bit may change
        if (WR) begin
            if (ADDR == `CATI_A_CNT_LO) begin
                if (!wdog) cnt_nxt[7:0] = WDATA;               // see [R17]
            end else if (ADDR == `CATI_A_CNT_HI) begin
                if (!wdog) cnt_nxt[15:8] = WDATA;
            end else if (ADDR == `CATI_A_MODE) begin
                if (wdog) mode_nxt[`CATI_MODE_WDOG] = WDATA[`CATI_MODE_WDOG];
                else mode_nxt = {WDATA[7:6], 2'h0, WDATA[3:0]}; // see [R17]
            end else if (ADDR == `CATI_A_FLAGS) begin
                flg_nxt = flg_r & {WDATA[7:6], 3'h7, WDATA[2:0]}; // see [R9]
                flg_nxt[5:3] = 3'h0;
            end else if (ADDR == `CATI_A_PWM) begin
                pwm_nxt = {1'b0, WDATA[6], 4'h0, WDATA[1:0]};
            end else if (ADDR == `CATI_A_CHAN) begin
                chan_nxt = {1'b0, WDATA[6:0]};
            end else if (ADDR == `CATI_A_IEN) begin
                ien_nxt = {WDATA[7], 6'h00, WDATA[0]};
            end
        end
        // counting; set of a flag wins over its clear
        if (inc) begin
            cnt_nxt = cnt_r + 16'h0001;                          // see [R19] see [R1]
            if (cnt_r == `CATI_CNT_MAX) flg_nxt[`CATI_FLG_CF] = 1'b1; // see [R7] see [R13]
            if (mid_carry) flg_nxt[`CATI_FLG_INTERMEDIATE_OVERFLOW_FLAG] = 1'b1;         // see [R11]
        end
        flg_nxt[2:0] = flg_nxt[2:0] | chan_rise;                  // see [R12] see [R13]
        // reads move data out and the low read loads the snapshot; the count is not touched
        if (RD) begin
            if (ADDR == `CATI_A_CNT_LO) begin
                rd_nxt   = cnt_r[7:0];                           // see [R3]
                snap_nxt = cnt_r[15:8];                          // see [R2]
            end else if (ADDR == `CATI_A_CNT_HI) begin
                rd_nxt = snap_r;                                 // see [R2]
            end else if (ADDR == `CATI_A_MODE) begin
                rd_nxt = mode_r;
            end else if (ADDR == `CATI_A_FLAGS) begin
                rd_nxt = flg_r;
            end else if (ADDR == `CATI_A_PWM) begin
                rd_nxt = pwm_r;
            end else if (ADDR == `CATI_A_CHAN) begin
                rd_nxt = chan_r;
            end else if (ADDR == `CATI_A_IEN) begin
                rd_nxt = ien_r;
            end else begin
                rd_nxt = 8'h00;
            end
        end
        // five gated flags, then the two-level global gate
        irq_nxt = ((flg_r[`CATI_FLG_CF] & mode_r[`CATI_MODE_ECF]) |   // see [R8]
                   (flg_r[`CATI_FLG_INTERMEDIATE_OVERFLOW_FLAG] & pwm_r[`CATI_PWM_INTERMEDIATE_OVERFLOW_IRQ_ENABLE]) |
                   |(flg_r[2:0] & chan_r[2:0]))                       // see [R14]
                  & ien_r[`CATI_IEN_GLOB] & ien_r[`CATI_IEN_ARR];     // see [R15]
    end

    // ****************************************
    // state registers
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_r      <= 16'h0000;
            snap_r     <= 8'h00;
            mode_r     <= `CATI_MODE_RST;  // see [R17]
            flg_r      <= 8'h00;
            pwm_r      <= 8'h00;
            chan_r     <= 8'h00;
            ien_r      <= 8'h00;
            p12_r      <= 4'h0;
            p4_r       <= 2'h0;
            pe_r       <= 3'h0;
            pl_r       <= 3'h0;
            RDATA      <= 8'h00;
            IRQ        <= 1'b0;
            TIMEBASE   <= 16'h0000;
            CHAN_IO_O  <= 3'h0;
            CHAN_IO_OE <= 3'h0;
            WDOG_ON    <= 1'b1;
        end else begin
            cnt_r      <= cnt_nxt;
            snap_r     <= snap_nxt;
            mode_r     <= mode_nxt;
            flg_r      <= flg_nxt;
            pwm_r      <= pwm_nxt;
            chan_r     <= chan_nxt;
            ien_r      <= ien_nxt;
            p12_r      <= p12_nxt;
            p4_r       <= p4_nxt;
            pe_r       <= pe_nxt;
            pl_r       <= pl_nxt;
            RDATA      <= rd_nxt;
            IRQ        <= irq_nxt;
            TIMEBASE   <= cnt_nxt;         // see [R16]
            CHAN_IO_O  <= chan_nxt[6:4];
            CHAN_IO_OE <= chan_nxt[2:0];   // see [R16]
            WDOG_ON    <= mode_nxt[`CATI_MODE_WDOG];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    a_ovf_flag_set: assert property (@(posedge CLK) disable iff (!RST_N)  // see [R7]
        inc && cnt_r == 16'hFFFF |=> flg_r[7] && cnt_r == 16'h0000)
        else $error("overflow flag not set on wrap");
    a_count_step: assert property (@(posedge CLK) disable iff (!RST_N)    // see [R19]
        inc |=> cnt_r == $past(cnt_r) + 16'h0001)
        else $error("count did not step by one");
    a_read_no_effect: assert property (@(posedge CLK) disable iff (!RST_N) // see [R3]
        RD && !cnt_wr |=> cnt_r == $past(cnt_r) + {15'h0000, $past(inc)})
        else $error("read disturbed the count");
    a_reserved_quiet: assert property (@(posedge CLK) disable iff (!RST_N) // see [R19]
        sel == CATI_TB_RSVD |-> !tick)
        else $error("reserved selector ticked");
    a_idle_hold: assert property (@(posedge CLK) disable iff (!RST_N)     // see [R20]
        mode_r[7] && CPU_IDLE && !cnt_wr |=> cnt_r == $past(cnt_r))
        else $error("count moved in suspended idle");
    a_snap_read: assert property (@(posedge CLK) disable iff (!RST_N)     // see [R2]
        RD && ADDR == 8'h00 ##1 RD && ADDR == 8'h01 |=> RDATA == $past(cnt_r[15:8], 2))
        else $error("high read missed the snapshot");
    a_div4_gap: assert property (@(posedge CLK) disable iff (!RST_N)      // see [R4]
        sel == CATI_TB_DIV4 && tick && $stable(sel) |=> !tick [*3])
        else $error("divide by four ticked too often");
    a_ovf_sticky: assert property (@(posedge CLK) disable iff (!RST_N)    // see [R9]
        flg_r[7] && !ovf_clr |=> flg_r[7])
        else $error("overflow flag dropped without software");
    a_irq_gate: assert property (@(posedge CLK) disable iff (!RST_N)      // see [R15]
        !(ien_r[7] && ien_r[0]) |=> !IRQ)
        else $error("irq raised without both global enables");
    a_mid_flag: assert property (@(posedge CLK) disable iff (!RST_N)      // see [R11]
        inc && pwm_r[1:0] == 2'h0 && cnt_r[7:0] == 8'hFF |=> flg_r[6])
        else $error("intermediate flag missed 8-bit carry");
    a_wdog_guard: assert property (@(posedge CLK) disable iff (!RST_N)    // see [R17]
        wdog && WR && ADDR == `CATI_A_MODE |=> {mode_r[7], mode_r[5:0]} == $past({mode_r[7], mode_r[5:0]}))
        else $error("mode changed while watchdog on");
    a_ovf_irq_out: assert property (@(posedge CLK) disable iff (!RST_N)   // see [R8]
        flg_r[`CATI_FLG_CF] && mode_r[`CATI_MODE_ECF] && ien_r[`CATI_IEN_GLOB] && ien_r[`CATI_IEN_ARR] |=> IRQ)
        else $error("enabled overflow flag gave no irq");
    // a channel edge must reach its flag even under a software clear
    a_chan_flag_set: assert property (@(posedge CLK) disable iff (!RST_N) // see [R13]
        |chan_rise |=> (flg_r[2:0] & $past(chan_rise)) == $past(chan_rise))
        else $error("channel event flag not set");

endmodule : cati_top

// ===== rtl/cati_map.svh
// Purpose: offsets, field positions and counts of the counter array
// Assumes: byte-wide register port, 100 MHz CLK
// Notes:   definitions only
`ifndef CATI_MAP_SVH
`define CATI_MAP_SVH
// ****************************************
// register offsets
// ****************************************
`define CATI_A_CNT_LO   8'h00
`define CATI_A_CNT_HI   8'h01
`define CATI_A_MODE     8'h02
`define CATI_A_FLAGS    8'h03
`define CATI_A_PWM      8'h04
`define CATI_A_CHAN     8'h05
`define CATI_A_IEN      8'h06
// ****************************************
// field positions
// ****************************************
`define CATI_MODE_IDLE  7
`define CATI_MODE_WDOG  6
`define CATI_MODE_ECF   0
`define CATI_FLG_CF     7
`define CATI_FLG_INTERMEDIATE_OVERFLOW_FLAG   6
`define CATI_PWM_INTERMEDIATE_OVERFLOW_IRQ_ENABLE   6
`define CATI_IEN_GLOB   7
`define CATI_IEN_ARR    0
// ****************************************
// reset values and counts
// ****************************************
`define CATI_MODE_RST   8'h40
`define CATI_DIV12_LAST 4'hB
`define CATI_DIV4_LAST  2'h3
`define CATI_DIV8_LAST  3'h7
`define CATI_CNT_MAX    16'hFFFF
`endif

// ===== rtl/cati_pkg.sv
// Purpose: types shared by the counter array
// Assumes: constants live in cati_map.svh
// Notes:   selector codes follow the timebase table
package cati_pkg;
    typedef enum logic [2:0] {
        CATI_TB_DIV12 = 3'h0,
        CATI_TB_DIV4  = 3'h1,
        CATI_TB_T0OVF = 3'h2,
        CATI_TB_ECI   = 3'h3,
        CATI_TB_SYS   = 3'h4,
        CATI_TB_EXTO  = 3'h5,
        CATI_TB_LFO   = 3'h6,
        CATI_TB_RSVD  = 3'h7
    } cati_tb_t;
    typedef logic [7:0] cati_byte_t;
endpackage : cati_pkg

// ===== bench/cati_top_bench.sv
// Purpose: self-checking bench for the counter array
// Assumes: byte register port, read data one cycle after the strobe
// Notes:   clock prescaler phase is unknown, so the clock-divided rates get a tolerance of one
`timescale 1ns/1ns
`include "cati_map.svh"
module cati_top_bench;
    import cati_pkg::*;
    logic        clk, rst_n, wr, rd, cpu_idle, t0_ovf, eci_in, ext_osc, lf_osc, irq, wdog_on;
    logic [7:0]  addr, rdata, b;
    cati_byte_t  wdata;
    logic [2:0]  chan_evt, io_o, io_oe;
    logic [15:0] tb, w, t0;
    int          num_errors, n_checks;

    cati_top uut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CPU_IDLE(cpu_idle), .T0_OVF(t0_ovf), .ECI_IN(eci_in), .EXT_OSC(ext_osc), .LF_OSC(lf_osc),
        .CHAN_EVT(chan_evt), .TIMEBASE(tb), .CHAN_IO_O(io_o), .CHAN_IO_OE(io_oe), .WDOG_ON(wdog_on), .IRQ(irq));

    // ****************************************
    // clock and bus tasks
    // ****************************************
    // 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    // data appear at the edge after the strobe and hold until the next read, so sample just past that edge
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    // low first so the high byte comes from the snapshot
    task automatic rd_cnt(output logic [15:0] v);
        rd_reg(`CATI_A_CNT_LO, v[7:0]);
        rd_reg(`CATI_A_CNT_HI, v[15:8]);
    endtask : rd_cnt
    task automatic load_cnt(input logic [15:0] v);
        wr_reg(`CATI_A_CNT_LO, v[7:0]);
        wr_reg(`CATI_A_CNT_HI, v[15:8]);
    endtask : load_cnt
    // park on the reserved code so the load is not raced by ticks
    task automatic start_src(input logic [2:0] sel, input logic [15:0] v);
        wr_reg(`CATI_A_MODE, 8'h0E);
        load_cnt(v);
        wr_reg(`CATI_A_MODE, {4'h0, sel, 1'b0});
    endtask : start_src
    task automatic stop_cnt(output logic [15:0] v);
        wr_reg(`CATI_A_MODE, 8'h0E);
        rd_cnt(v);
    endtask : stop_cnt

    // ****************************************
    // compares and closing
    // ****************************************
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp, input int tol);
        n_checks++;
        if ($isunknown(got) || got > exp + tol || got + tol < exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp16
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    // bounded wait; running out is a mismatch and ends the run
    task automatic wait_irq(input logic exp);
        for (int i = 0; i < 20; i++) begin
            if (irq === exp) break;
            @(posedge clk);
        end
        cmp8({7'h00, irq}, {7'h00, exp});
        if (irq !== exp) wrap_up();
    endtask : wait_irq

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        cpu_idle = 1'b0;
        t0_ovf = 1'b0;
        eci_in = 1'b1;
        ext_osc = 1'b0;
        lf_osc = 1'b0;
        chan_evt = 3'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        cmp8({6'h00, wdog_on, irq}, 8'h02);
        rst_n <= 1'b1;
        rd_reg(`CATI_A_MODE, b);
        cmp8(b, `CATI_MODE_RST);
        // watchdog blocks count writes and all mode bits but its own
        wr_reg(`CATI_A_CNT_HI, 8'hAA);
        rd_cnt(w);
        cmp8(w[15:8], 8'h00);
        wr_reg(`CATI_A_MODE, 8'h0E);
        rd_reg(`CATI_A_MODE, b);
        cmp8(b, 8'h00);
        cmp8({7'h00, wdog_on}, 8'h00);
        rd_reg(8'h07, b);
        cmp8(b, 8'h00);
        // snapshot holds the high byte seen at the low read
        start_src(3'h7, 16'h1234);
        cmp16(tb, 16'h1234, 0);
        rd_reg(`CATI_A_CNT_LO, b);
        cmp8(b, 8'h34);
        wr_reg(`CATI_A_CNT_HI, 8'h56);
        rd_reg(`CATI_A_CNT_HI, b);
        cmp8(b, 8'h12);
        rd_cnt(w);
        cmp16(w, 16'h5634, 0);
        // clock-derived rates; only the divided ones have an unknown phase
        start_src(3'h0, 16'h0000);
        repeat (96) @(posedge clk);
        stop_cnt(w);
        cmp16(w, 16'd8, 1);
        start_src(3'h1, 16'h0000);
        repeat (96) @(posedge clk);
        stop_cnt(w);
        cmp16(w, 16'd24, 1);
        start_src(3'h4, 16'h0000);
        repeat (40) @(posedge clk);
        stop_cnt(w);
        cmp16(w, 16'd42, 0);
        // other timer overflow pulses
        start_src(3'h2, 16'h0000);
        repeat (5) begin
            t0_ovf <= 1'b1;
            @(posedge clk);
            t0_ovf <= 1'b0;
            repeat (2) @(posedge clk);
        end
        stop_cnt(w);
        cmp16(w, 16'd5, 0);
        // pin falls at one eighth of the clock, within the allowed rate
        start_src(3'h3, 16'h0000);
        repeat (6) begin
            eci_in <= 1'b0;
            repeat (4) @(posedge clk);
            eci_in <= 1'b1;
            repeat (4) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        stop_cnt(w);
        cmp16(w, 16'd6, 0);
        // both oscillators, sixteen rising edges each
        for (int s = 0; s < 2; s++) begin
            start_src(s == 0 ? 3'h5 : 3'h6, 16'h0000);
            repeat (16) begin
                if (s == 0) ext_osc <= 1'b1;
                else lf_osc <= 1'b1;
                repeat (3) @(posedge clk);
                if (s == 0) ext_osc <= 1'b0;
                else lf_osc <= 1'b0;
                repeat (3) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            stop_cnt(w);
            cmp16(w, 16'd2, 0);
        end
        // reads inside the window must not cost any ticks
        start_src(3'h4, 16'h0000);
        cpu_idle <= 1'b1;
        #1 t0 = tb;
        rd_cnt(w);
        repeat (16) @(posedge clk);
        #1;
        cmp16(tb, t0 + 16'd20, 0);
        wr_reg(`CATI_A_MODE, 8'h88);
        repeat (3) @(posedge clk);
        #1 t0 = tb;
        repeat (20) @(posedge clk);
        #1;
        cmp16(tb, t0, 0);
        @(posedge clk);
        cpu_idle <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        cmp8({7'h00, tb > t0}, 8'h01);
        // full wrap with every enable off, then the enable chain
        start_src(3'h7, 16'hFFFC);
        wr_reg(`CATI_A_FLAGS, 8'h00);
        wr_reg(`CATI_A_MODE, 8'h08);
        repeat (10) @(posedge clk);
        stop_cnt(w);
        cmp16(w, 16'h0008, 0);
        rd_reg(`CATI_A_FLAGS, b);
        cmp8(b, 8'hC0);
        wr_reg(`CATI_A_IEN, 8'h81);
        repeat (3) @(posedge clk);
        cmp8({7'h00, irq}, 8'h00);
        wr_reg(`CATI_A_MODE, 8'h0F);
        wait_irq(1'b1);
        wr_reg(`CATI_A_IEN, 8'h80);
        wait_irq(1'b0);
        // irq is already low here, so give a wrong gate time to raise it
        wr_reg(`CATI_A_IEN, 8'h01);
        repeat (3) @(posedge clk);
        wait_irq(1'b0);
        wr_reg(`CATI_A_IEN, 8'h81);
        wait_irq(1'b1);
        rd_reg(`CATI_A_FLAGS, b);
        cmp8(b, 8'hC0);
        wr_reg(`CATI_A_FLAGS, 8'h7F);
        wait_irq(1'b0);
        rd_reg(`CATI_A_FLAGS, b);
        cmp8(b, 8'h40);
        wr_reg(`CATI_A_PWM, 8'h40);
        wait_irq(1'b1);
        wr_reg(`CATI_A_FLAGS, 8'h00);
        wait_irq(1'b0);
        // intermediate carry for every cycle length
        for (int k = 0; k < 4; k++) begin
            wr_reg(`CATI_A_PWM, {6'h00, k[1:0]});
            start_src(3'h7, 16'((32'h100 << k) - 4));
            wr_reg(`CATI_A_FLAGS, 8'h00);
            wr_reg(`CATI_A_MODE, 8'h08);
            repeat (10) @(posedge clk);
            stop_cnt(w);
            rd_reg(`CATI_A_FLAGS, b);
            cmp8(b, 8'h40);
        end
        // a nine-bit cycle ignores the carry out of bit 7
        wr_reg(`CATI_A_PWM, 8'h01);
        start_src(3'h7, 16'h00FC);
        wr_reg(`CATI_A_FLAGS, 8'h00);
        wr_reg(`CATI_A_MODE, 8'h08);
        repeat (10) @(posedge clk);
        stop_cnt(w);
        rd_reg(`CATI_A_FLAGS, b);
        cmp8(b, 8'h00);
        // channel events set flags whatever the enables say
        @(posedge clk);
        chan_evt <= 3'h5;
        repeat (6) @(posedge clk);
        rd_reg(`CATI_A_FLAGS, b);
        cmp8(b, 8'h05);
        wr_reg(`CATI_A_CHAN, 8'h32);
        repeat (3) @(posedge clk);
        cmp8({2'h0, io_o, io_oe}, 8'h1A);
        cmp8({7'h00, irq}, 8'h00);
        chan_evt <= 3'h7;
        wait_irq(1'b1);
        chan_evt <= 3'h0;
        // a second reset in mid-run brings the watchdog mode back
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        cmp8({6'h00, wdog_on, irq}, 8'h02);
        rst_n <= 1'b1;
        rd_reg(`CATI_A_MODE, b);
        cmp8(b, `CATI_MODE_RST);
        wrap_up();
    end
endmodule : cati_top_bench
